// *** fpe_pkg.sv ***
// fpe_pkg: constants for the flash program/erase control block.
// assumes one 250 MHz system clock; no software-visible registers.
package fpe_pkg;
  localparam int CF_READ_CYC = 2;
  localparam int DF_READ_CYC = 6;
  localparam int CF_AW = 14;           // 64 KB user area, 32-bit words
  localparam int DF_AW = 10;           // 1 KB data area, bytes
  localparam int CF_WORDS_64K = 16384;
  localparam int CF_WORDS_32K = 8192;
  localparam int CF_BLK_WORDS = 512;   // 2 KB erase block
  localparam int DF_BLK_BYTES = 256;
  localparam logic [31:0] CTRL_BASE = 32'h407E_0000;
  localparam logic [31:0] CTRL_MASK = 32'hFFFE_0000;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [127:0] BLANK_ID = {128{1'b1}};
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_PROG = 2'h1;
  localparam logic [1:0] CMD_ERASE = 2'h2;
  typedef enum logic [1:0] {
    FPE_IDLE = 2'b00,
    FPE_PROG = 2'b01,
    FPE_ERASE = 2'b10
  } fpe_state_t;
endpackage : fpe_pkg

// *** fpe_flash_ctrl.sv ***
// fpe_flash_ctrl: code/data flash read paths, command sequencer, debug id gate.
// assumes the requester holds a read request until its ready pulse,
// and flags as an error any command given before the synchronised oscillator is stable.
`timescale 1ns/1ps
module fpe_flash_ctrl (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic variant_32k,
  input wire logic cf_rd_req,
  input wire logic [fpe_pkg::CF_AW-1:0] cf_rd_addr,
  output logic cf_rd_ready,
  output logic [31:0] cf_rd_data,
  input wire logic df_rd_req,
  input wire logic [fpe_pkg::DF_AW-1:0] df_rd_addr,
  output logic df_rd_ready,
  output logic [7:0] df_rd_data,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_reg_addr,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_data_flash,
  input wire logic [fpe_pkg::CF_AW-1:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic osc_stable,
  output logic cmd_busy,
  output logic cmd_done,
  output logic cmd_error,
  input wire logic irq_in,
  output logic irq_out,
  input wire logic [127:0] id_code,
  input wire logic id_lock_always,
  input wire logic dbg_key_valid,
  input wire logic [127:0] dbg_key,
  output logic dbg_allow
);
  localparam int CF_AWL = fpe_pkg::CF_AW;

  logic [31:0] cf_mem [fpe_pkg::CF_WORDS_64K];
  logic [7:0] df_mem [2**fpe_pkg::DF_AW];

  function automatic logic in_ctrl(input logic [31:0] a);
    return (a & fpe_pkg::CTRL_MASK) == fpe_pkg::CTRL_BASE;
  endfunction : in_ctrl

  // read pipelines: shift a request token through fixed-length delay lines
  logic [fpe_pkg::CF_READ_CYC-1:0] cf_pipe_reg, cf_pipe_next;
  logic [fpe_pkg::DF_READ_CYC-1:0] df_pipe_reg, df_pipe_next;
  logic [CF_AWL-1:0] cf_addr_reg, cf_addr_next;
  logic [fpe_pkg::DF_AW-1:0] df_addr_reg, df_addr_next;
  logic cf_ready_next, df_ready_next;
  logic [31:0] cf_data_next;
  logic [7:0] df_data_next;

  // sequencer state
  fpe_pkg::fpe_state_t st_reg, st_next;
  logic busy_df_reg, busy_df_next;
  logic [CF_AWL-1:0] op_addr_reg, op_addr_next;
  logic [31:0] op_data_reg, op_data_next;
  logic [CF_AWL-1:0] er_cnt_reg, er_cnt_next;
  logic done_next, err_next, busy_next;
  logic cf_busy, df_busy;
  logic wr_en;
  logic [CF_AWL-1:0] wr_addr;
  logic [31:0] wr_word;
  logic wr_df;
  logic cf_oob;

  // strap/pin sync
  logic var_s1_reg, var_s2_reg, osc_s1_reg, osc_s2_reg;
  logic dbg_next;
  logic irq_next;
  // key match latch, kept apart so a blank-id opening never survives an id being set
  logic key_ok_reg, key_ok_next;

  assign cf_busy = (st_reg != fpe_pkg::FPE_IDLE) && !busy_df_reg;
  assign df_busy = (st_reg != fpe_pkg::FPE_IDLE) && busy_df_reg;

  always_comb begin
    // a busy array holds its request; the other array keeps streaming
    cf_pipe_next = {cf_pipe_reg[fpe_pkg::CF_READ_CYC-2:0], cf_rd_req && !cf_busy && !(|cf_pipe_reg)};
    df_pipe_next = {df_pipe_reg[fpe_pkg::DF_READ_CYC-2:0], df_rd_req && !df_busy && !(|df_pipe_reg)};
    cf_addr_next = cf_pipe_next[0] ? cf_rd_addr : cf_addr_reg;
    df_addr_next = df_pipe_next[0] ? df_rd_addr : df_addr_reg;
    cf_ready_next = cf_pipe_reg[fpe_pkg::CF_READ_CYC-2];
    df_ready_next = df_pipe_reg[fpe_pkg::DF_READ_CYC-2];
    cf_data_next = cf_ready_next ? cf_mem[cf_addr_reg] : cf_rd_data;
    df_data_next = df_ready_next ? df_mem[df_addr_reg] : df_rd_data;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cf_pipe_reg <= '0;
      df_pipe_reg <= '0;
      cf_addr_reg <= '0;
      df_addr_reg <= '0;
      cf_rd_ready <= 1'b0;
      df_rd_ready <= 1'b0;
      cf_rd_data <= '0;
      df_rd_data <= '0;
    end else begin
      cf_pipe_reg <= cf_pipe_next;
      df_pipe_reg <= df_pipe_next;
      cf_addr_reg <= cf_addr_next;
      df_addr_reg <= df_addr_next;
      cf_rd_ready <= cf_ready_next;
      df_rd_ready <= df_ready_next;
      cf_rd_data <= cf_data_next;
      df_rd_data <= df_data_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      var_s1_reg <= 1'b0;
      var_s2_reg <= 1'b0;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
    end else begin
      var_s1_reg <= variant_32k;
      var_s2_reg <= var_s1_reg;
      osc_s1_reg <= osc_stable;
      osc_s2_reg <= osc_s1_reg;
    end
  end

  // top half of the code array is absent on the small variant
  assign cf_oob = var_s2_reg && cmd_addr[CF_AWL-1];

  always_comb begin
    st_next = st_reg;
    busy_df_next = busy_df_reg;
    op_addr_next = op_addr_reg;
    op_data_next = op_data_reg;
    er_cnt_next = er_cnt_reg;
    done_next = 1'b0;
    err_next = 1'b0;
    wr_en = 1'b0;
    wr_addr = op_addr_reg;
    wr_word = op_data_reg;
    wr_df = busy_df_reg;
    case (st_reg)
      fpe_pkg::FPE_IDLE: begin
        if (cmd_valid && in_ctrl(cmd_reg_addr)) begin
          // a bad command or a dead oscillator is flagged, never run
          if (!osc_s2_reg || (!cmd_data_flash && cf_oob) || cmd_op == fpe_pkg::CMD_NONE || cmd_op == 2'h3) begin
            err_next = 1'b1;
          end else begin
            busy_df_next = cmd_data_flash;
            op_data_next = cmd_wdata;
            if (cmd_op == fpe_pkg::CMD_PROG) begin
              st_next = fpe_pkg::FPE_PROG;
              op_addr_next = cmd_addr;
            end else begin
              st_next = fpe_pkg::FPE_ERASE;
              // align to the erase block of the chosen array
              op_addr_next = cmd_data_flash ?
                {cmd_addr[CF_AWL-1:8], 8'h00} : {cmd_addr[CF_AWL-1:9], 9'h000};
              er_cnt_next = cmd_data_flash ?
                CF_AWL'(fpe_pkg::DF_BLK_BYTES - 1) : CF_AWL'(fpe_pkg::CF_BLK_WORDS - 1);
            end
          end
        end
      end
      fpe_pkg::FPE_PROG: begin
        wr_en = 1'b1;
        done_next = 1'b1;
        st_next = fpe_pkg::FPE_IDLE;
      end
      fpe_pkg::FPE_ERASE: begin
        wr_en = 1'b1;
        wr_word = fpe_pkg::ERASED_WORD;
        op_addr_next = op_addr_reg + CF_AWL'(1);
        er_cnt_next = er_cnt_reg - CF_AWL'(1);
        if (er_cnt_reg == '0) begin
          done_next = 1'b1;
          st_next = fpe_pkg::FPE_IDLE;
        end
      end
      default: st_next = fpe_pkg::FPE_IDLE;
    endcase
    busy_next = (st_next != fpe_pkg::FPE_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= fpe_pkg::FPE_IDLE;
      busy_df_reg <= 1'b0;
      op_addr_reg <= '0;
      op_data_reg <= '0;
      er_cnt_reg <= '0;
      cmd_busy <= 1'b0;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      st_reg <= st_next;
      busy_df_reg <= busy_df_next;
      op_addr_reg <= op_addr_next;
      op_data_reg <= op_data_next;
      er_cnt_reg <= er_cnt_next;
      cmd_busy <= busy_next;
      cmd_done <= done_next;
      cmd_error <= err_next;
    end
  end

  // arrays have no reset, like real flash cells
  always_ff @(posedge sys_clk) begin
    if (wr_en && wr_df) begin
      df_mem[wr_addr[fpe_pkg::DF_AW-1:0]] <= wr_word[7:0];
    end
    if (wr_en && !wr_df) begin
      cf_mem[wr_addr] <= wr_word;
    end
  end

  always_comb begin
    irq_next = irq_in;
    key_ok_next = key_ok_reg;
    if (id_code == fpe_pkg::BLANK_ID) begin
      dbg_next = 1'b1;
      key_ok_next = 1'b0;
    end else if (id_lock_always) begin
      dbg_next = 1'b0;
      key_ok_next = 1'b0;
    end else begin
      key_ok_next = key_ok_reg | (dbg_key_valid && dbg_key == id_code);
      dbg_next = key_ok_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_out <= 1'b0;
      dbg_allow <= 1'b0;
      key_ok_reg <= 1'b0;
    end else begin
      irq_out <= irq_next;
      dbg_allow <= dbg_next;
      key_ok_reg <= key_ok_next;
    end
  end

  cf_read_lat_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(cf_pipe_reg[0]) |-> ##1 cf_rd_ready) else $error("code read not ready in 2 cycles");
  df_read_lat_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(df_pipe_reg[0]) |-> ##5 df_rd_ready) else $error("data read not ready in 6 cycles");
  bgo_cf_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    df_busy && cf_rd_req && !(|cf_pipe_reg) |=> cf_pipe_reg[0]) else $error("code read stalled");
  df_stall_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    df_busy |=> !df_pipe_reg[0]) else $error("data read ran during data op");
  osc_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg == fpe_pkg::FPE_IDLE && !osc_s2_reg |=> st_reg == fpe_pkg::FPE_IDLE) else $error("op without osc");
  prog_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg == fpe_pkg::FPE_PROG |=> cmd_done && !cmd_busy) else $error("program not one cycle");
  sequence er_start_s;
    st_reg == fpe_pkg::FPE_IDLE ##1 st_reg == fpe_pkg::FPE_ERASE && busy_df_reg;
  endsequence
  df_erase_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    er_start_s |-> ##255 st_reg == fpe_pkg::FPE_ERASE ##1 st_reg == fpe_pkg::FPE_IDLE) else $error("df erase len");
  decode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_valid && !in_ctrl(cmd_reg_addr) |=> !cmd_error && !cmd_done) else $error("decode leak");
  irq_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> irq_out == $past(irq_in)) else $error("irq blocked");
  blank_id_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    id_code == fpe_pkg::BLANK_ID |=> dbg_allow) else $error("blank id locked");
  lock_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    id_code != fpe_pkg::BLANK_ID && id_lock_always |=> !dbg_allow) else $error("lock open");
  // set id: only a presented match may open the port
  key_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    id_code != fpe_pkg::BLANK_ID && !key_ok_reg && !dbg_key_valid |=> !dbg_allow) else $error("open without key");
  // code reads wait out a code op, never see a half-written word
  cf_stall_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cf_busy |=> !cf_pipe_reg[0]) else $error("code read ran during code op");
  bad_op_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg == fpe_pkg::FPE_IDLE && cmd_valid && in_ctrl(cmd_reg_addr) && cmd_op == 2'h3 |=> cmd_error && !cmd_busy)
    else $error("bad op not flagged");
  sequence cf_er_start_s;
    st_reg == fpe_pkg::FPE_IDLE ##1 st_reg == fpe_pkg::FPE_ERASE && !busy_df_reg;
  endsequence
  cf_erase_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cf_er_start_s |-> er_cnt_reg == CF_AWL'(fpe_pkg::CF_BLK_WORDS - 1)) else $error("cf erase len");
  erase_fill_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg == fpe_pkg::FPE_ERASE |-> wr_en && wr_word == fpe_pkg::ERASED_WORD) else $error("erase not ones");
  df_prog_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg == fpe_pkg::FPE_PROG && busy_df_reg |-> wr_en && wr_df) else $error("data program lost");
endmodule : fpe_flash_ctrl

// *** fpe_core_model.sv ***
// fpe_core_model: processor-side code flash reader for background traffic.
// assumes reads are held until the ready pulse, as the read port expects.
`timescale 1ns/1ps
module fpe_core_model (
  input wire logic sys_clk,
  input wire logic en,
  input wire logic [fpe_pkg::CF_AW-1:0] addr,
  output logic cf_rd_req,
  output logic [fpe_pkg::CF_AW-1:0] cf_rd_addr,
  input wire logic cf_rd_ready,
  output int reads,
  output int late
);
  int cnt;
  initial begin
    reads = 0;
    late = 0;
    cnt = 0;
  end
  assign cf_rd_req = en;
  // released address must not look like a held one
  assign cf_rd_addr = en ? addr : ~addr;
  always @(posedge sys_clk) begin
    if (!en) begin
      cnt <= 0;
    end else if (cf_rd_ready) begin
      reads <= reads + 1;
      if (cnt != fpe_pkg::CF_READ_CYC) begin
        late <= late + 1;
      end
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : fpe_core_model

// *** tb_top.sv ***
// tb_top: self-checking bench for the flash program/erase control block.
// assumes fpe_pkg and the core model are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0, rst_b = 0, variant_32k = 0, df_rd_req = 0, cmd_valid = 0, cmd_data_flash = 0;
  logic osc_stable = 1, irq_in = 0, id_lock_always = 0, dbg_key_valid = 0, m_en = 0;
  logic [9:0] df_rd_addr = 10'h000;
  logic [13:0] cmd_addr = 14'h0000, m_addr = 14'h0000, cf_rd_addr;
  logic [31:0] cmd_reg_addr = 32'h0000_0000, cmd_wdata = 32'h0000_0000, cf_rd_data;
  logic [1:0] cmd_op = 2'h0;
  logic [127:0] id_code = fpe_pkg::BLANK_ID, dbg_key = {4{32'h0000_0000}};
  logic [7:0] df_rd_data, b;
  logic cf_rd_req, cf_rd_ready, df_rd_ready, cmd_busy, cmd_done, cmd_error, irq_out, dbg_allow, e;
  int error_cnt = 0, checks = 0, n, reads, late, r0;
  fpe_flash_ctrl i_fpe_flash_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .variant_32k(variant_32k),
    .cf_rd_req(cf_rd_req), .cf_rd_addr(cf_rd_addr), .cf_rd_ready(cf_rd_ready), .cf_rd_data(cf_rd_data),
    .df_rd_req(df_rd_req), .df_rd_addr(df_rd_addr), .df_rd_ready(df_rd_ready), .df_rd_data(df_rd_data),
    .cmd_valid(cmd_valid), .cmd_reg_addr(cmd_reg_addr), .cmd_op(cmd_op), .cmd_data_flash(cmd_data_flash),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .osc_stable(osc_stable), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done), .cmd_error(cmd_error), .irq_in(irq_in), .irq_out(irq_out), .id_code(id_code),
    .id_lock_always(id_lock_always), .dbg_key_valid(dbg_key_valid), .dbg_key(dbg_key), .dbg_allow(dbg_allow));
  fpe_core_model i_fpe_core_model (.sys_clk(sys_clk), .en(m_en), .addr(m_addr), .cf_rd_req(cf_rd_req),
    .cf_rd_addr(cf_rd_addr), .cf_rd_ready(cf_rd_ready), .reads(reads), .late(late));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic cmd(input logic [1:0] op, input logic df, input logic [13:0] a, input logic [31:0] ra);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1;
    cmd_op = op;
    cmd_data_flash = df;
    cmd_addr = a;
    cmd_reg_addr = ra;
    @(posedge sys_clk);
    #1;
    cmd_valid = 0;
    n = 1;
    while (cmd_done !== 1'b1 && cmd_error !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    e = cmd_error;
  endtask : cmd
  task automatic rd_df(input logic [9:0] a);
    @(posedge sys_clk);
    #1;
    df_rd_req = 1;
    df_rd_addr = a;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (df_rd_ready !== 1'b1 && n < 600);
    df_rd_req = 0;
    df_rd_addr = ~a;
    b = df_rd_data;
  endtask : rd_df
  task automatic rd_cf(input logic [13:0] a);
    @(posedge sys_clk);
    #1;
    m_addr = a;
    m_en = 1;
    r0 = reads;
    while (reads == r0) begin
      @(posedge sys_clk);
      #1;
    end
    m_en = 0;
    chk(late == 0, "code read latency");
  endtask : rd_cf
  task automatic t_code;
    cmd_wdata = 32'h5A3C_96E1;
    cmd(fpe_pkg::CMD_PROG, 0, 14'h0205, fpe_pkg::CTRL_BASE);
    chk(n == 2 && e === 1'b0, "code program");
    rd_cf(14'h0205);
    chk(cf_rd_data === 32'h5A3C_96E1, "code readback");
    cmd(fpe_pkg::CMD_ERASE, 0, 14'h0205, 32'h407F_FFFC);
    chk(n == 513 && e === 1'b0, "code erase");
    rd_cf(14'h0205);
    chk(cf_rd_data === fpe_pkg::ERASED_WORD, "code erased");
  endtask : t_code
  task automatic t_data;
    cmd_wdata = 32'h0000_00A5;
    cmd(fpe_pkg::CMD_PROG, 1, 14'h01FF, fpe_pkg::CTRL_BASE);
    chk(n == 2 && e === 1'b0, "data program");
    rd_df(10'h1FF);
    chk(n == fpe_pkg::DF_READ_CYC && b === 8'hA5, "data read");
    m_en = 1;
    r0 = reads;
    fork
      cmd(fpe_pkg::CMD_ERASE, 1, 14'h0100, fpe_pkg::CTRL_BASE);
      begin
        repeat (20) @(posedge sys_clk);
        #1;
        irq_in = 1;
        @(posedge sys_clk);
        #1;
        chk(irq_out === 1'b1 && cmd_busy === 1'b1, "irq during erase");
        irq_in = 0;
      end
    join
    m_en = 0;
    chk(n == 257 && reads - r0 > 80 && late == 0, "background reads");
    rd_df(10'h1FF);
    chk(b === fpe_pkg::ERASED_BYTE, "data erased");
  endtask : t_data
  task automatic t_refuse;
    cmd(fpe_pkg::CMD_PROG, 0, 14'h0010, 32'h4080_0000);
    chk(n == 600 && cmd_busy === 1'b0, "out of range taken");
    cmd(2'h3, 0, 14'h0010, fpe_pkg::CTRL_BASE);
    chk(n == 1 && e === 1'b1, "bad op");
    variant_32k = 1;
    repeat (3) @(posedge sys_clk);
    cmd(fpe_pkg::CMD_PROG, 0, 14'h2000, fpe_pkg::CTRL_BASE);
    chk(n == 1 && e === 1'b1, "upper half in 32k");
    variant_32k = 0;
    osc_stable = 0;
    repeat (3) @(posedge sys_clk);
    cmd(fpe_pkg::CMD_PROG, 0, 14'h0010, fpe_pkg::CTRL_BASE);
    chk(n == 1 && e === 1'b1, "oscillator not stable");
    osc_stable = 1;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : t_refuse
  task automatic t_id;
    chk(dbg_allow === 1'b1, "blank id open");
    id_code = {4{32'h1357_9BDF}};
    repeat (2) @(posedge sys_clk);
    #1;
    chk(dbg_allow === 1'b0, "set id closed");
    dbg_key = {4{32'h1357_9BDE}};
    dbg_key_valid = 1;
    @(posedge sys_clk);
    #1;
    dbg_key_valid = 0;
    chk(dbg_allow === 1'b0, "wrong key");
    dbg_key = id_code;
    dbg_key_valid = 1;
    @(posedge sys_clk);
    #1;
    dbg_key_valid = 0;
    @(posedge sys_clk);
    #1;
    chk(dbg_allow === 1'b1, "matching key");
    id_lock_always = 1;
    dbg_key_valid = 1;
    repeat (2) @(posedge sys_clk);
    #1;
    dbg_key_valid = 0;
    chk(dbg_allow === 1'b0, "locked always");
  endtask : t_id
  task automatic summarize;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  initial begin
    // sized for 10000 cycles, several times the traffic of the tests
    #40000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1;
    repeat (3) @(posedge sys_clk);
    t_code();
    t_data();
    t_refuse();
    t_id();
    summarize();
  end
endmodule : tb_top
